// >>> hw/nvmac_top.v
// nvm access control register, table latch, table pointer and axi4-lite slave
//
// How it works
// (R1) erase bit set with space select set: next start erases addressed row; erase completion clears it
// (R2) reset during a self-timed cycle sets the abort flag; normal completion leaves 0
// (R3) abort recording keeps space and config select bits unchanged
// (R4) permit bit gates every write and erase cycle
// (R5) start bit launches a self-timed cycle; hardware clears it at finish
// (R6) software can only set the start bit; writing 0 does nothing
// (R7) fetch bit does a one-cycle eeprom read (configuration read when config select is set), then clears itself
// (R8) fetch bit cannot be set while program memory is selected
// (R9) 8-bit table latch holds each byte moved by table instructions
// (R10) pointer is upper, high and low bytes joined into 22 bits
// (R11) low 21 pointer bits address up to 2 Mbytes of program space
// (R12) pointer top bit set steers accesses to id and configuration space
// (R13) automatic pointer updates change only the low 21 bits
// (R14) table ops keep, post-increment, post-decrement or pre-increment the pointer
// (R15) space select routes to program memory when set, eeprom when clear
// (R16) config select routes to configuration registers regardless of space select
// (R17) software writes 55h then AAh to the key port before setting start
// (R18) after a reset that aborted a cycle the start bit reads cleared
`timescale 1ns/1ps
`default_nettype none
`include "nvmac_defines.vh"

module nvmac_top #(
  parameter PTR_W = 22
) (
  input  wire              clk_i,           // core clock, 125 MHz
  input  wire              resetn_i,        // async reset, active low
  input  wire              cyc_pending_i,   // retained: a self-timed cycle was running at reset
  input  wire [7:0]        s_axi_awaddr_i,  // write address
  input  wire              s_axi_awvalid_i, // write address valid
  output wire              s_axi_awready_o, // write address ready
  input  wire [31:0]       s_axi_wdata_i,   // write data
  input  wire [3:0]        s_axi_wstrb_i,   // write strobes
  input  wire              s_axi_wvalid_i,  // write data valid
  output wire              s_axi_wready_o,  // write data ready
  output wire [1:0]        s_axi_bresp_o,   // write response
  output wire              s_axi_bvalid_o,  // write response valid
  input  wire              s_axi_bready_i,  // write response ready
  input  wire [7:0]        s_axi_araddr_i,  // read address
  input  wire              s_axi_arvalid_i, // read address valid
  output wire              s_axi_arready_o, // read address ready
  output wire [31:0]       s_axi_rdata_o,   // read data
  output wire [1:0]        s_axi_rresp_o,   // read response
  output wire              s_axi_rvalid_o,  // read data valid
  input  wire              s_axi_rready_i,  // read data ready
  input  wire              tbl_req_i,       // table instruction strobe
  input  wire              tbl_store_i,     // 1 store instr, 0 fetch instr
  input  wire [1:0]        tbl_mode_i,      // pointer update mode
  input  wire [7:0]        tbl_wdata_i,     // byte from data ram for stores
  output wire              tbl_ack_o,       // access taken (same cycle)
  output reg  [20:0]       mem_addr_o,      // byte address into selected space
  output reg  [1:0]        mem_target_o,    // selected space
  output reg               mem_rd_o,        // one-cycle fetch strobe
  output reg               mem_wr_o,        // one-cycle holding-register store
  input  wire [7:0]        mem_rdata_i,     // fetched byte, valid with mem_rd_o
  output reg               cyc_start_o,     // self-timed cycle launch pulse
  output reg               cyc_erase_o,     // launched cycle is a row erase
  input  wire              cyc_done_i,      // self-timed cycle finished
  output wire              cyc_busy_o,      // cycle in progress
  output wire              irq_o            // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  reg  [5:0]       ctrl_reg;
  reg  [1:0]       sel_reg;
  reg  [7:0]       latch_reg;
  reg  [PTR_W-1:0] ptr_reg;
  reg  [1:0]       key_reg;
  reg  [2:0]       stat_reg;
  reg  [2:0]       mask_reg;
  reg              fetch_pend_reg;
  reg              tbl_rd_pend_reg;
  reg              init_reg;
  reg              aw_held_reg;
  reg              w_held_reg;
  reg  [7:0]       aw_addr_reg;
  reg  [31:0]      w_data_reg;
  reg  [3:0]       w_strb_reg;
  reg              bvalid_reg;
  reg              rvalid_reg;
  reg  [31:0]      rdata_reg;
  reg  [1:0]       rresp_reg;
  reg  [1:0]       bresp_reg;
  // space and config select live apart: they survive a reset that aborts a cycle
  wire [7:0]       ctrl_all = {sel_reg, ctrl_reg};

  // pick space from the select bits and the pointer's top bit
  function [1:0] nvmac_target;
    input [7:0] ctrl;
    input       top;
    begin
      if (ctrl[`NVMAC_BIT_CFG])
        nvmac_target = `NVMAC_TGT_CONFIG;                             // see (R16)
      else if (!ctrl[`NVMAC_BIT_SPACE])
        nvmac_target = `NVMAC_TGT_EEPROM;                             // see (R15)
      else if (top)
        nvmac_target = `NVMAC_TGT_IDSPACE;                            // see (R12)
      else
        nvmac_target = `NVMAC_TGT_PROGRAM;
    end
  endfunction

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a[1:0] == 2'b00) && (a <= `NVMAC_OFF_MASK);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite handshakes
  assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready_o  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;

  wire        aw_hs  = s_axi_awvalid_i && s_axi_awready_o;
  wire        w_hs   = s_axi_wvalid_i && s_axi_wready_o;
  wire        have_a = aw_held_reg || aw_hs;
  wire        have_w = w_held_reg || w_hs;
  wire        wr_go  = have_a && have_w && !bvalid_reg;
  wire [7:0]  wa     = aw_held_reg ? aw_addr_reg : s_axi_awaddr_i;
  wire [31:0] wd     = w_held_reg ? w_data_reg : s_axi_wdata_i;
  wire [3:0]  ws     = w_held_reg ? w_strb_reg : s_axi_wstrb_i;
  wire        wb0    = wr_go && ws[0];
  wire        ar_hs  = s_axi_arvalid_i && s_axi_arready_o;

  wire busy   = ctrl_reg[`NVMAC_BIT_START];
  wire [20:0] low_inc = ptr_reg[20:0] + 21'h00_0001;
  wire [20:0] low_dec = ptr_reg[20:0] - 21'h00_0001;
  wire        tbl_go  = tbl_req_i && !busy;

  assign tbl_ack_o  = tbl_go;
  assign cyc_busy_o = busy;
  assign irq_o      = |(stat_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // bus write and read channels
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'b00;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= 2'b00;
    end else begin
      if (aw_hs && !wr_go) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (w_hs && !wr_go) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= is_mapped(wa) ? 2'b00 : 2'b10;
      end else if (s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
      if (ar_hs) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= is_mapped(s_axi_araddr_i) ? 2'b00 : 2'b10;
        case (s_axi_araddr_i)
          `NVMAC_OFF_CTRL:     rdata_reg <= {24'h00_0000, ctrl_all};
          `NVMAC_OFF_LATCH:    rdata_reg <= {24'h00_0000, latch_reg};
          `NVMAC_OFF_PTR_LOW:  rdata_reg <= {24'h00_0000, ptr_reg[7:0]};
          `NVMAC_OFF_PTR_HIGH: rdata_reg <= {24'h00_0000, ptr_reg[15:8]};
          `NVMAC_OFF_PTR_UP:   rdata_reg <= {26'h000_0000, ptr_reg[21:16]};
          `NVMAC_OFF_STATUS:   rdata_reg <= {29'h0000_0000, stat_reg};
          `NVMAC_OFF_MASK:     rdata_reg <= {29'h0000_0000, mask_reg};
          default:             rdata_reg <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready_i) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register, unlock key, table pointer and latch
  wire key_open = (key_reg == 2'd2);
  wire sw_ctrl  = wb0 && (wa == `NVMAC_OFF_CTRL);
  wire sw_start = sw_ctrl && wd[`NVMAC_BIT_START] && !busy && key_open
                  && wd[`NVMAC_BIT_PERMIT];                           // see (R4) (R17)
  wire sw_fetch = sw_ctrl && wd[`NVMAC_BIT_FETCH] && !busy
                  && !wd[`NVMAC_BIT_SPACE] && !ctrl_all[`NVMAC_BIT_SPACE]; // see (R8)
  // the written byte decides the space of the access it launches
  wire [1:0] tgt_now = nvmac_target(wd[7:0], ptr_reg[21]);

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg        <= 6'h00;
      latch_reg       <= 8'h00;
      ptr_reg         <= {PTR_W{1'b0}};
      key_reg         <= 2'd0;
      stat_reg        <= 3'h0;
      mask_reg        <= 3'h0;
      fetch_pend_reg  <= 1'b0;
      tbl_rd_pend_reg <= 1'b0;
      init_reg        <= 1'b1;
      mem_addr_o      <= 21'h00_0000;
      mem_target_o    <= 2'b00;
      mem_rd_o        <= 1'b0;
      mem_wr_o        <= 1'b0;
      cyc_start_o     <= 1'b0;
      cyc_erase_o     <= 1'b0;
    end else begin
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      cyc_start_o <= 1'b0;
      init_reg    <= 1'b0;
      // abort is caught one edge after release; start bit stays 0
      if (init_reg && cyc_pending_i) begin
        ctrl_reg[`NVMAC_BIT_ABORT] <= 1'b1;                           // see (R2) (R3) (R18)
        stat_reg[`NVMAC_IRQ_ABORT] <= 1'b1;
      end
      if (wb0 && wa == `NVMAC_OFF_KEY) begin
        if (wd[7:0] == `NVMAC_KEY_FIRST)
          key_reg <= 2'd1;
        else if (wd[7:0] == `NVMAC_KEY_SECOND && key_reg == 2'd1)
          key_reg <= 2'd2;
        else
          key_reg <= 2'd0;
      end else if (wb0) begin
        key_reg <= 2'd0;
      end
      if (sw_ctrl) begin
        ctrl_reg[`NVMAC_BIT_ERASE]  <= wd[`NVMAC_BIT_ERASE];
        ctrl_reg[`NVMAC_BIT_PERMIT] <= wd[`NVMAC_BIT_PERMIT];
        if (!(init_reg && cyc_pending_i))
          ctrl_reg[`NVMAC_BIT_ABORT] <= wd[`NVMAC_BIT_ABORT];
      end
      if (sw_start) begin
        ctrl_reg[`NVMAC_BIT_START] <= 1'b1;                           // see (R5) (R6)
        ctrl_reg[`NVMAC_BIT_ABORT] <= 1'b0;
        cyc_start_o  <= 1'b1;
        cyc_erase_o  <= wd[`NVMAC_BIT_ERASE] && wd[`NVMAC_BIT_SPACE];     // see (R1)
        mem_target_o <= tgt_now;
        mem_addr_o   <= ptr_reg[20:0];
      end else if (busy && cyc_done_i) begin
        ctrl_reg[`NVMAC_BIT_START] <= 1'b0;                           // see (R5)
        if (cyc_erase_o)
          ctrl_reg[`NVMAC_BIT_ERASE] <= 1'b0;                         // see (R1)
        cyc_erase_o <= 1'b0;
        stat_reg[`NVMAC_IRQ_DONE] <= 1'b1;
      end
      if (sw_fetch) begin
        ctrl_reg[`NVMAC_BIT_FETCH] <= 1'b1;                           // see (R7)
        fetch_pend_reg <= 1'b1;
        mem_rd_o       <= 1'b1;
        mem_target_o   <= tgt_now;                                    // see (R16)
        mem_addr_o     <= ptr_reg[20:0];
      end else if (fetch_pend_reg) begin
        ctrl_reg[`NVMAC_BIT_FETCH] <= 1'b0;                           // see (R7)
        fetch_pend_reg <= 1'b0;
        latch_reg      <= mem_rdata_i;
        stat_reg[`NVMAC_IRQ_FETCH] <= 1'b1;
      end
      // a fetched byte lands even when a table fetch follows at once; a store then wins
      if (tbl_rd_pend_reg)
        latch_reg <= mem_rdata_i;                                     // see (R9)
      if (tbl_go) begin
        mem_target_o <= (ptr_reg[21] ? `NVMAC_TGT_IDSPACE : `NVMAC_TGT_PROGRAM); // see (R12)
        mem_addr_o   <= (tbl_mode_i == `NVMAC_MODE_PREINC) ? low_inc : ptr_reg[20:0]; // see (R11)
        mem_rd_o     <= !tbl_store_i;
        mem_wr_o     <= tbl_store_i;
        tbl_rd_pend_reg <= !tbl_store_i;
        if (tbl_store_i)
          latch_reg <= tbl_wdata_i;                                   // see (R9)
        case (tbl_mode_i)                                             // see (R14) (R13)
          `NVMAC_MODE_POSTINC: ptr_reg[20:0] <= low_inc;
          `NVMAC_MODE_POSTDEC: ptr_reg[20:0] <= low_dec;
          `NVMAC_MODE_PREINC:  ptr_reg[20:0] <= low_inc;
          default:             ptr_reg[20:0] <= ptr_reg[20:0];
        endcase
      end else begin
        tbl_rd_pend_reg <= 1'b0;
      end
      if (wb0 && !tbl_go) begin
        case (wa)                                                     // see (R10)
          `NVMAC_OFF_LATCH:    latch_reg      <= wd[7:0];
          `NVMAC_OFF_PTR_LOW:  ptr_reg[7:0]   <= wd[7:0];
          `NVMAC_OFF_PTR_HIGH: ptr_reg[15:8]  <= wd[7:0];
          `NVMAC_OFF_PTR_UP:   ptr_reg[21:16] <= wd[5:0];
          default:             ptr_reg        <= ptr_reg;
        endcase
      end
      if (wb0 && wa == `NVMAC_OFF_MASK)
        mask_reg <= wd[2:0];
      if (wb0 && wa == `NVMAC_OFF_STATUS) begin
        // write one clears; a new event in the same cycle wins
        stat_reg[`NVMAC_IRQ_DONE]  <= (stat_reg[`NVMAC_IRQ_DONE] & ~wd[`NVMAC_IRQ_DONE])
                                      | (busy & cyc_done_i & !sw_start);
        stat_reg[`NVMAC_IRQ_FETCH] <= (stat_reg[`NVMAC_IRQ_FETCH] & ~wd[`NVMAC_IRQ_FETCH])
                                      | (fetch_pend_reg & !sw_fetch);
        stat_reg[`NVMAC_IRQ_ABORT] <= (stat_reg[`NVMAC_IRQ_ABORT] & ~wd[`NVMAC_IRQ_ABORT])
                                      | (init_reg & cyc_pending_i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // select bits have no reset of their own: a reset that aborts a cycle keeps them
  always @(posedge clk_i) begin
    if (resetn_i && sw_ctrl) begin
      sel_reg <= {wd[`NVMAC_BIT_SPACE], wd[`NVMAC_BIT_CFG]};
    end else if (init_reg && !cyc_pending_i) begin
      sel_reg <= 2'b00;                                               // see (R3)
    end
  end

endmodule
`default_nettype wire

// >>> common/nvmac_defines.vh
// register offsets, field positions, key values and codes of the nvm access block
`ifndef NVMAC_DEFINES_VH
`define NVMAC_DEFINES_VH

`define NVMAC_OFF_CTRL     8'h00
`define NVMAC_OFF_LATCH    8'h04
`define NVMAC_OFF_PTR_LOW  8'h08
`define NVMAC_OFF_PTR_HIGH 8'h0C
`define NVMAC_OFF_PTR_UP   8'h10
`define NVMAC_OFF_KEY      8'h14
`define NVMAC_OFF_STATUS   8'h18
`define NVMAC_OFF_MASK     8'h1C

`define NVMAC_BIT_FETCH    0
`define NVMAC_BIT_START    1
`define NVMAC_BIT_PERMIT   2
`define NVMAC_BIT_ABORT    3
`define NVMAC_BIT_ERASE    4
`define NVMAC_BIT_CFG      6
`define NVMAC_BIT_SPACE    7

`define NVMAC_KEY_FIRST    8'h55
`define NVMAC_KEY_SECOND   8'hAA

`define NVMAC_IRQ_DONE     0
`define NVMAC_IRQ_FETCH    1
`define NVMAC_IRQ_ABORT    2

`define NVMAC_MODE_KEEP    2'b00
`define NVMAC_MODE_POSTINC 2'b01
`define NVMAC_MODE_POSTDEC 2'b10
`define NVMAC_MODE_PREINC  2'b11

`define NVMAC_TGT_EEPROM   2'b00
`define NVMAC_TGT_PROGRAM  2'b01
`define NVMAC_TGT_CONFIG   2'b10
`define NVMAC_TGT_IDSPACE  2'b11

`endif

// >>> sim/nvmac_mem_model.sv
// memory and programming-timer model at the far side of the block
`timescale 1ns/1ps
`default_nettype none
module nvmac_mem_model (
  input  wire logic        clk_i,    // core clock
  input  wire logic        resetn_i, // async reset, active low
  input  wire logic [20:0] addr_i,   // byte address
  input  wire logic        rd_i,     // fetch strobe
  input  wire logic        start_i,  // cycle launch
  input  wire logic [7:0]  salt_i,   // data pattern
  input  wire logic [7:0]  delay_i,  // cycle length
  output logic      [7:0]  rdata_o,  // fetched byte
  output logic             done_o    // cycle finished
);
  logic [7:0] cnt_reg;
  logic       run_reg;
  // byte is only valid with the strobe; inverted otherwise
  assign rdata_o = rd_i ? (addr_i[7:0] ^ salt_i) : ~(addr_i[7:0] ^ salt_i);
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_reg <= 1'b0;
      cnt_reg <= 8'h00;
      done_o  <= 1'b0;
    end else begin
      done_o <= run_reg && cnt_reg == 8'h00;
      if (start_i) begin
        run_reg <= 1'b1;
        cnt_reg <= delay_i;
      end else if (run_reg && cnt_reg == 8'h00) begin
        run_reg <= 1'b0;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/nvmac_top_props.sv
// assertions on the ports of the nvm access block
`timescale 1ns/1ps
`default_nettype none
`include "nvmac_defines.vh"
module nvmac_top_props #(
  parameter PTR_W = 22
) (
  input wire logic        clk_i,       // clock
  input wire logic        resetn_i,    // reset
  input wire logic        tbl_req_i,   // table request
  input wire logic        tbl_store_i, // store
  input wire logic [1:0]  tbl_mode_i,  // update mode
  input wire logic        tbl_ack_o,   // taken
  input wire logic [20:0] mem_addr_o,  // address
  input wire logic        mem_rd_o,    // fetch strobe
  input wire logic        mem_wr_o,    // store strobe
  input wire logic        cyc_start_o, // launch
  input wire logic        cyc_erase_o, // erase cycle
  input wire logic        cyc_done_i,  // finished
  input wire logic        cyc_busy_o   // in progress
);
  logic acc;
  assign acc = tbl_req_i && tbl_ack_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_start_busy: assert property (cyc_start_o |-> cyc_busy_o)
    else $error("launch without busy");
  a_busy_hold: assert property (cyc_busy_o && !cyc_done_i |=> cyc_busy_o)
    else $error("busy dropped early");
  a_busy_clear: assert property (cyc_busy_o && cyc_done_i |=> !cyc_busy_o)
    else $error("busy kept after done");
  a_erase_launch: assert property ($rose(cyc_erase_o) |-> cyc_start_o)
    else $error("erase without launch");
  a_ack_gate: assert property (tbl_req_i |-> tbl_ack_o == !cyc_busy_o)
    else $error("table ack wrong");
  a_fetch_strobe: assert property (acc && !tbl_store_i |=> mem_rd_o && !mem_wr_o)
    else $error("no fetch strobe");
  a_store_strobe: assert property (acc && tbl_store_i |=> mem_wr_o && !mem_rd_o)
    else $error("no store strobe");
  a_post_inc: assert property (acc && tbl_mode_i == `NVMAC_MODE_POSTINC ##1 acc
    && tbl_mode_i != `NVMAC_MODE_PREINC |=> mem_addr_o == $past(mem_addr_o) + 21'h00_0001)
    else $error("bad post increment");
  a_post_dec: assert property (acc && tbl_mode_i == `NVMAC_MODE_POSTDEC ##1 acc
    && tbl_mode_i != `NVMAC_MODE_PREINC |=> mem_addr_o == $past(mem_addr_o) - 21'h00_0001)
    else $error("bad post decrement");
  a_reset_idle: assert property ($rose(resetn_i) |-> !cyc_busy_o)
    else $error("busy after reset");
  cover property (acc && tbl_mode_i == `NVMAC_MODE_PREINC);
  cover property (cyc_start_o && cyc_erase_o);
  cover property (cyc_busy_o && cyc_done_i);
endmodule
bind nvmac_top nvmac_top_props #(.PTR_W(PTR_W)) i_props (
  .clk_i(clk_i), .resetn_i(resetn_i), .tbl_req_i(tbl_req_i), .tbl_store_i(tbl_store_i),
  .tbl_mode_i(tbl_mode_i), .tbl_ack_o(tbl_ack_o), .mem_addr_o(mem_addr_o),
  .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .cyc_start_o(cyc_start_o),
  .cyc_erase_o(cyc_erase_o), .cyc_done_i(cyc_done_i), .cyc_busy_o(cyc_busy_o));
`default_nettype wire

// >>> sim/tb.sv
// self-checking testbench of the nvm access block
`timescale 1ns/1ps
`default_nettype none
`include "nvmac_defines.vh"
module tb;
  localparam [7:0] CT = `NVMAC_OFF_CTRL;
  localparam [7:0] ST = `NVMAC_OFF_STATUS;
  logic        clk_i = 1'b0, resetn_i = 1'b0, pend = 1'b0, req = 1'b0, store = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, er = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00, salt = 8'h00, dly = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rv;
  logic [1:0]  mode = 2'b00, rr;
  logic [21:0] p;
  wire         awr, wr_r, bv, arr, rvl, ack, mrd, mwr, st, ers, dn, busy, irq;
  wire  [1:0]  br, rrs, tgt;
  wire  [31:0] rd_d;
  wire  [20:0] ma;
  wire  [7:0]  md;
  integer      mismatches = 0, n_tests = 0, n_st = 0, n_wr = 0, k, i, m;
  logic [20:0] qa[$], ea[$];
  logic [1:0]  qt[$];
  always #4 clk_i = ~clk_i;
  nvmac_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .cyc_pending_i(pend),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r), .s_axi_bresp_o(br),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd_d), .s_axi_rresp_o(rrs), .s_axi_rvalid_o(rvl),
    .s_axi_rready_i(1'b1), .tbl_req_i(req), .tbl_store_i(store), .tbl_mode_i(mode),
    .tbl_wdata_i(salt), .tbl_ack_o(ack), .mem_addr_o(ma), .mem_target_o(tgt), .mem_rd_o(mrd),
    .mem_wr_o(mwr), .mem_rdata_i(md), .cyc_start_o(st), .cyc_erase_o(ers), .cyc_done_i(dn),
    .cyc_busy_o(busy), .irq_o(irq));
  nvmac_mem_model i_mem (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(ma), .rd_i(mrd),
    .start_i(st), .salt_i(salt), .delay_i(dly), .rdata_o(md), .done_o(dn));
  always @(posedge clk_i) begin
    if (mrd) begin
      qa.push_back(ma);
      qt.push_back(tgt);
    end
    n_wr = n_wr + mwr;
    n_st = n_st + st;
    if (ers) er = 1'b1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task automatic stop_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task automatic hang(input integer lim);
    if (k >= lim) begin
      mismatches = mismatches + 1;
      $display("ERROR %0t: no answer", $time);
      stop_test;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw;
    begin
      ta = 1'b0;
      tw = 1'b0;
      awa <= a;
      wd <= {24'h00_0000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      k = 0;
      do begin
        @(posedge clk_i);
        k = k + 1;
        ta = ta | awr;
        tw = tw | wr_r;
        if (ta) awv <= 1'b0;
        if (tw) wv <= 1'b0;
      end while (!(ta && tw) && k < 50);
      do begin @(posedge clk_i); k = k + 1; end while (!bv && k < 100);
      hang(100);
      rr = br;
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    begin
      ara <= a;
      arv <= 1'b1;
      k = 0;
      do begin @(posedge clk_i); k = k + 1; end while (!arr && k < 50);
      arv <= 1'b0;
      do begin @(posedge clk_i); k = k + 1; end while (!rvl && k < 100);
      hang(100);
      rr = rrs;
      chk(rd_d, e);
    end
  endtask
  task automatic key;
    begin
      wr(`NVMAC_OFF_KEY, `NVMAC_KEY_FIRST);
      wr(`NVMAC_OFF_KEY, `NVMAC_KEY_SECOND);
    end
  endtask
  task automatic idle;
    begin
      k = 0;
      do begin @(posedge clk_i); k = k + 1; end while (busy && k < 400);
      hang(400);
    end
  endtask
  task automatic rst;
    begin
      resetn_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      pend <= 1'b0;
    end
  endtask
  initial begin
    rv = $urandom(82455);
    rst;
    for (i = 0; i < 8; i = i + 1) if (i != 5) rc({i[5:0], 2'b00}, 32'h0000_0000);
    rc(8'h20, 32'h0000_0000);
    chk(rr, 2'b10);
    wr(8'h01, 8'h01);
    chk(rr, 2'b10);
    $display("test reset and map done");
    for (i = 0; i < 2; i = i + 1) begin
      rv = $urandom;
      salt <= rv[31:24];
      p = {i[0], i[0] ? 21'h1F_FFFF : rv[20:0]};
      wr(`NVMAC_OFF_PTR_LOW, p[7:0]);
      wr(`NVMAC_OFF_PTR_HIGH, p[15:8]);
      wr(`NVMAC_OFF_PTR_UP, {2'b00, p[21:16]});
      qa.delete();
      qt.delete();
      ea.delete();
      for (m = 0; m < 7; m = m + 1) begin
        mode <= (m == 1) ? `NVMAC_MODE_POSTINC : (m == 3) ? `NVMAC_MODE_POSTDEC :
                (m == 5) ? `NVMAC_MODE_PREINC : `NVMAC_MODE_KEEP;
        req <= 1'b1;
        if (m == 5) p[20:0] = p[20:0] + 21'h00_0001;
        ea.push_back(p[20:0]);
        if (m == 1) p[20:0] = p[20:0] + 21'h00_0001;
        if (m == 3) p[20:0] = p[20:0] - 21'h00_0001;
        @(posedge clk_i);
      end
      req <= 1'b0;
      repeat (3) @(posedge clk_i);
      for (m = 0; m < 7; m = m + 1) begin
        chk(qa[m], ea[m]);
        chk(qt[m], p[21] ? `NVMAC_TGT_IDSPACE : `NVMAC_TGT_PROGRAM);
      end
      rc(`NVMAC_OFF_LATCH, {24'h00_0000, ea[6][7:0] ^ salt});
      req <= 1'b1;
      store <= 1'b1;
      @(posedge clk_i);
      req <= 1'b0;
      store <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(n_wr, i + 1);
      rc(`NVMAC_OFF_LATCH, {24'h00_0000, salt});
      rc(`NVMAC_OFF_PTR_LOW, {24'h00_0000, p[7:0]});
      rc(`NVMAC_OFF_PTR_HIGH, {24'h00_0000, p[15:8]});
      rc(`NVMAC_OFF_PTR_UP, {26'h000_0000, p[21:16]});
    end
    $display("test table pointer done");
    qt.delete();
    wr(CT, 8'h01);
    rc(CT, 32'h0000_0000);
    rc(ST, 32'h0000_0002);
    wr(ST, 8'h02);
    wr(CT, 8'h41);
    wr(CT, 8'hC1);
    rc(CT, 32'h0000_00C0);
    chk(qt.size(), 2);
    chk(qt[0], `NVMAC_TGT_EEPROM);
    chk(qt[1], `NVMAC_TGT_CONFIG);
    wr(ST, 8'h02);
    $display("test fetch done");
    wr(`NVMAC_OFF_MASK, 8'h07);
    dly <= $urandom_range(8'h63, 8'h3C);
    wr(CT, 8'h86);
    rc(CT, 32'h0000_0084);
    key;
    wr(CT, 8'h82);
    rc(CT, 32'h0000_0080);
    chk(n_st, 0);
    key;
    wr(CT, 8'h96);
    wr(CT, 8'h94);
    rc(CT, 32'h0000_0096);
    chk({n_st[7:0], 7'h00, er}, 16'h0101);
    idle;
    rc(CT, 32'h0000_0084);
    rc(ST, 32'h0000_0001);
    chk(irq, 1'b1);
    wr(ST, 8'h01);
    chk(irq, 1'b0);
    er = 1'b0;
    dly <= 8'h00;
    key;
    wr(CT, 8'h06);
    idle;
    rc(CT, 32'h0000_0004);
    chk({n_st[7:0], 7'h00, er}, 16'h0200);
    wr(`NVMAC_OFF_MASK, 8'h00);
    chk(irq, 1'b0);
    wr(`NVMAC_OFF_MASK, 8'h01);
    chk(irq, 1'b1);
    wr(ST, 8'h01);
    $display("test program cycle done");
    dly <= 8'hC8;
    key;
    wr(CT, 8'hC6);
    pend <= 1'b1;
    rst;
    rc(CT, 32'h0000_00C8);
    rc(ST, 32'h0000_0004);
    dly <= 8'h04;
    key;
    wr(CT, 8'h06);
    idle;
    rc(CT, 32'h0000_0004);
    $display("test abort done");
    stop_test;
  end
endmodule
`default_nettype wire
